// File: logic/grr_rate_readout.sv
// read-side registers of the gyro rate channels and first status byte
// Functional notes
// - low read freezes high byte until read
// - host reads low before high for consistency
// - y low byte at 0x04
// - y high byte at 0x05
// - z low byte at 0x06
// - z high byte at 0x07
// - 0x08 reserved, reads zero
// - 0x09: any-motion bit 2, high-rate bit 1
// - x low 0x02, high 0x03, same locking
module grr_rate_readout
    import grr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        shadow_dis,
    input  wire logic        data_ready,
    input  wire logic        powering_up,
    input  wire logic        deep_suspend,
    input  wire logic [15:0] rate_x,
    input  wire logic [15:0] rate_y,
    input  wire logic [15:0] rate_z,
    input  wire logic        any_motion_evt,
    input  wire logic        high_rate_evt,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_addr,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic             data_invalid
);
    logic       blocked;
    logic       upd;
    logic       rd_ok;
    logic [2:0] rd_lo;
    logic [2:0] rd_hi;
    logic [7:0] low_b   [3];
    logic [7:0] high_b  [3];
    logic [2:0] lock_s;
    logic [15:0] samp   [3];
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       any_r;
    logic       high_r;
    logic       inval_r;

    // reads in power-up or deep suspend carry no valid data
    assign blocked = powering_up | deep_suspend;
    assign upd     = data_ready & ~blocked;
    assign rd_ok   = rd_en & ~blocked;
    assign samp[0] = rate_x;
    assign samp[1] = rate_y;
    assign samp[2] = rate_z;

    // a burst ascends low then high, so the lock releases on its own
    assign rd_lo[0] = rd_ok && rd_addr == GRR_ADDR_X_LOW;
    assign rd_hi[0] = rd_ok && rd_addr == GRR_ADDR_X_HIGH;
    assign rd_lo[1] = rd_ok && rd_addr == GRR_ADDR_Y_LOW;
    assign rd_hi[1] = rd_ok && rd_addr == GRR_ADDR_Y_HIGH;
    assign rd_lo[2] = rd_ok && rd_addr == GRR_ADDR_Z_LOW;
    assign rd_hi[2] = rd_ok && rd_addr == GRR_ADDR_Z_HIGH;

    for (genvar i = 0; i < 3; i++) begin : g_axis
        grr_axis_shadow u_axis (
            .clk          (clk),
            .resetn       (resetn),
            .ce           (ce),
            .shadow_dis   (shadow_dis),
            .sample_valid (upd),
            .sample_in    (samp[i]),
            .rd_low       (rd_lo[i]),
            .rd_high      (rd_hi[i]),
            .low_byte     (low_b[i]),
            .high_byte    (high_b[i]),
            .locked       (lock_s[i])
        );
    end

    // event status: set wins over the read that would clear it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            any_r  <= 1'b0;
            high_r <= 1'b0;
        end else if (ce) begin
            if (any_motion_evt) begin
                any_r <= 1'b1;
            end else if (rd_ok && rd_addr == GRR_ADDR_STATUS0) begin
                any_r <= 1'b0;
            end
            if (high_rate_evt) begin
                high_r <= 1'b1;
            end else if (rd_ok && rd_addr == GRR_ADDR_STATUS0) begin
                high_r <= 1'b0;
            end
        end
    end

    // registered read data, one cycle after the request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r  <= GRR_RDATA_RESET;
            rvalid_r <= 1'b0;
            inval_r  <= 1'b0;
        end else if (ce) begin
            rvalid_r <= rd_en;
            inval_r  <= rd_en & blocked;
            if (rd_en) begin
                unique case (rd_addr)
                    GRR_ADDR_X_LOW:   rdata_r <= low_b[0];
                    GRR_ADDR_X_HIGH:  rdata_r <= high_b[0];
                    GRR_ADDR_Y_LOW:   rdata_r <= low_b[1];
                    GRR_ADDR_Y_HIGH:  rdata_r <= high_b[1];
                    GRR_ADDR_Z_LOW:   rdata_r <= low_b[2];
                    GRR_ADDR_Z_HIGH:  rdata_r <= high_b[2];
                    GRR_ADDR_RSVD:    rdata_r <= GRR_RSVD_VALUE;
                    GRR_ADDR_STATUS0: begin
                        rdata_r <= 8'h00;
                        rdata_r[GRR_BIT_ANY]  <= any_r;
                        rdata_r[GRR_BIT_HIGH] <= high_r;
                    end
                    default:          rdata_r <= GRR_RDATA_RESET;
                endcase
            end
        end
    end

    assign rd_data      = rdata_r;
    assign rd_valid     = rvalid_r;
    assign data_invalid = inval_r;

    // helpers: reference samples taken from the inputs, apart from the axis logic
    logic [15:0] y_ref_chk;
    logic [15:0] z_ref_chk;
    logic [7:0]  y_hold_chk;
    logic [7:0]  z_hold_chk;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            y_ref_chk <= GRR_SAMPLE_RESET;
            z_ref_chk <= GRR_SAMPLE_RESET;
        end else if (ce && data_ready && !powering_up && !deep_suspend) begin
            y_ref_chk <= rate_y;
            z_ref_chk <= rate_z;
        end
    end

    // high byte the host must see after a low read; repeated low reads re-capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            y_hold_chk <= GRR_SAMPLE_RESET[15:8];
            z_hold_chk <= GRR_SAMPLE_RESET[15:8];
        end else if (ce) begin
            if (rd_lo[1]) begin
                y_hold_chk <= y_ref_chk[15:8];
            end
            if (rd_lo[2]) begin
                z_hold_chk <= z_ref_chk[15:8];
            end
        end
    end

    property p_lock_after_low;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_lo[1] && !shadow_dis) |=> lock_s[1];
    endproperty
    a_lock_after_low: assert property (p_lock_after_low)
        else $error("y high byte not locked after low read");

    property p_high_frozen;
        @(posedge clk) disable iff (!resetn)
        (lock_s[1] && $past(lock_s[1]) && !$past(rd_lo[1])) |-> high_b[1] == $past(high_b[1]);
    endproperty
    a_high_frozen: assert property (p_high_frozen)
        else $error("y high byte changed while locked");

    property p_unlock_high;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_hi[1] && !rd_lo[1]) |=> !lock_s[1];
    endproperty
    a_unlock_high: assert property (p_unlock_high)
        else $error("lock not released by high read");

    property p_no_lock_dis;
        @(posedge clk) disable iff (!resetn)
        (ce && shadow_dis) |=> !lock_s[0] && !lock_s[1] && !lock_s[2];
    endproperty
    a_no_lock_dis: assert property (p_no_lock_dis)
        else $error("lock held with shadow disabled");

    property p_y_low;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_en && rd_addr == GRR_ADDR_Y_LOW) |=> rd_data == $past(y_ref_chk[7:0]);
    endproperty
    a_y_low: assert property (p_y_low)
        else $error("y low byte read wrong");

    property p_y_high_pair;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_hi[1] && lock_s[1]) |=> rd_data == y_hold_chk;
    endproperty
    a_y_high_pair: assert property (p_y_high_pair)
        else $error("y high byte not from locked sample");

    property p_rsvd;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_en && rd_addr == GRR_ADDR_RSVD) |=> rd_data == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved address read nonzero");

    property p_status;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_en && rd_addr == GRR_ADDR_STATUS0) |=>
            rd_data[7:3] == 5'h00 && !rd_data[0] && rd_data[2] == $past(any_r) &&
            rd_data[1] == $past(high_r);
    endproperty
    a_status: assert property (p_status)
        else $error("status byte layout wrong");

    property p_invalid;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_en && (powering_up || deep_suspend)) |=> data_invalid;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("read in power-up or deep suspend not flagged");

    property p_z_high;
        @(posedge clk) disable iff (!resetn)
        (ce && rd_en && rd_addr == GRR_ADDR_Z_HIGH) |=>
            rd_data == $past(lock_s[2] ? z_hold_chk : z_ref_chk[15:8]);
    endproperty
    a_z_high: assert property (p_z_high)
        else $error("z high byte read wrong");

    c_burst_y: cover property (@(posedge clk) disable iff (!resetn)
        rd_lo[1] ##1 rd_hi[1]);
    c_lock_new: cover property (@(posedge clk) disable iff (!resetn)
        lock_s[1] && upd);
    c_status_any: cover property (@(posedge clk) disable iff (!resetn)
        rd_valid && any_r);
endmodule : grr_rate_readout

// File: shared/grr_pkg.sv
// package of constants for the gyro rate readout register block
package grr_pkg;
    localparam logic [7:0] GRR_ADDR_X_LOW   = 8'h02;
    localparam logic [7:0] GRR_ADDR_X_HIGH  = 8'h03;
    localparam logic [7:0] GRR_ADDR_Y_LOW   = 8'h04;
    localparam logic [7:0] GRR_ADDR_Y_HIGH  = 8'h05;
    localparam logic [7:0] GRR_ADDR_Z_LOW   = 8'h06;
    localparam logic [7:0] GRR_ADDR_Z_HIGH  = 8'h07;
    localparam logic [7:0] GRR_ADDR_RSVD    = 8'h08;
    localparam logic [7:0] GRR_ADDR_STATUS0 = 8'h09;
    localparam int         GRR_BIT_ANY      = 2;
    localparam int         GRR_BIT_HIGH     = 1;
    localparam logic [7:0] GRR_RDATA_RESET  = 8'h00;
    localparam logic [7:0] GRR_RSVD_VALUE   = 8'h00;
    localparam logic [15:0] GRR_SAMPLE_RESET = 16'h0000;
endpackage : grr_pkg

// File: logic/grr_axis_shadow.sv
// one axis: sample register plus low-before-high shadow lock
module grr_axis_shadow
    import grr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        shadow_dis,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_in,
    input  wire logic        rd_low,
    input  wire logic        rd_high,
    output logic      [7:0]  low_byte,
    output logic      [7:0]  high_byte,
    output logic             locked
);
    logic [15:0] sample_r;
    logic [7:0]  high_hold_r;
    logic        lock_r;

    // live sample; always tracks new data so the low byte is fresh
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_r <= GRR_SAMPLE_RESET;
        end else if (ce && sample_valid) begin
            sample_r <= sample_in;
        end
    end

    // low read freezes the high byte until it is read; disabled shadow never locks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_r      <= 1'b0;
            high_hold_r <= GRR_SAMPLE_RESET[15:8];
        end else if (ce) begin
            if (shadow_dis) begin
                lock_r <= 1'b0;
            end else if (rd_low) begin
                lock_r      <= 1'b1;
                high_hold_r <= sample_r[15:8];
            end else if (rd_high) begin
                lock_r <= 1'b0;
            end
        end
    end

    assign low_byte  = sample_r[7:0];
    assign high_byte = lock_r ? high_hold_r : sample_r[15:8];
    assign locked    = lock_r;
endmodule : grr_axis_shadow

// File: verification/grr_host_model.sv
// host-side model that issues single register reads and two-read bursts
module grr_host_model (
    input  wire logic       clk,
    output logic            rd_en,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire logic       data_invalid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic timed_out = 1'b0;
    initial begin
        rd_en   = 1'b0;
        rd_addr = 8'h00;
    end
    // one read, answer taken one cycle later; the flag goes back to the caller to check
    task automatic do_read(input logic [7:0] a, output logic [7:0] d, output logic inv);
        @(negedge clk);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en     = 1'b0;
        rd_addr   = ~a; // released address shows a changed pattern
        timed_out = timed_out | (rd_valid !== 1'b1);
        d         = rd_data;
        inv       = data_invalid;
    endtask : do_read

    // two reads on consecutive cycles, the way an ascending burst issues them
    task automatic do_pair(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        @(negedge clk);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_addr   = a + 8'h01;
        timed_out = timed_out | (rd_valid !== 1'b1);
        d0        = rd_data;
        @(negedge clk);
        rd_en     = 1'b0;
        rd_addr   = ~rd_addr;
        timed_out = timed_out | (rd_valid !== 1'b1);
        d1        = rd_data;
    endtask : do_pair
endmodule : grr_host_model

// File: verification/test_grr_rate_readout.sv
// self-checking bench for the rate readout register block
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module test_grr_rate_readout
    import grr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        resetn, ce, shadow_dis, data_ready, powering_up, deep_suspend;
    logic [15:0] rate_x, rate_y, rate_z;
    logic        any_motion_evt, high_rate_evt, rd_en, rd_valid, data_invalid;
    logic [7:0]  rd_addr, rd_data;
    int          seed = 32'haa9e;
    int          fails = 0;
    int          n_tests = 0;
    int          m, ax, a;
    // behavioural model state
    logic [15:0] smp [3] = '{default: 16'h0000};
    logic [7:0]  hold [3];
    bit          lk [3] = '{default: 0};
    logic [7:0]  stat = 8'h00;

    always #12.5 clk = ~clk;

    grr_rate_readout i_dut (.clk(clk), .resetn(resetn), .ce(ce), .shadow_dis(shadow_dis),
        .data_ready(data_ready), .powering_up(powering_up), .deep_suspend(deep_suspend),
        .rate_x(rate_x), .rate_y(rate_y), .rate_z(rate_z), .any_motion_evt(any_motion_evt),
        .high_rate_evt(high_rate_evt), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .data_invalid(data_invalid));
    grr_host_model i_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .data_invalid(data_invalid));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // new random sample; with the clock held off the design must ignore it
    task automatic load(input logic en);
        @(negedge clk);
        ce         = en;
        rate_x     = 16'($random(seed));
        rate_y     = 16'($random(seed));
        rate_z     = 16'($random(seed));
        data_ready = 1'b1;
        @(negedge clk);
        data_ready = 1'b0;
        ce         = 1'b1;
        if (en) begin
            smp[0] = rate_x;
            smp[1] = rate_y;
            smp[2] = rate_z;
        end
    endtask : load

    // model one read: lock and clear-on-read effects; blocked reads change nothing
    task automatic model_rd(input logic [7:0] ad, input logic pw, output logic [7:0] e);
        int x;
        x = (int'(ad) - 2) / 2;
        e = 8'h00;
        if (ad >= GRR_ADDR_X_LOW && ad <= GRR_ADDR_Z_HIGH) begin
            e = ad[0] ? (lk[x] ? hold[x] : smp[x][15:8]) : smp[x][7:0];
            if (!pw && !ad[0] && !shadow_dis) begin
                lk[x]   = 1;
                hold[x] = smp[x][15:8];
            end
            if (!pw && ad[0]) lk[x] = 0;
        end
        if (ad == GRR_ADDR_STATUS0 && !pw) begin
            e    = stat;
            stat = 8'h00;
        end
    endtask : model_rd

    // read through the host and compare with the model
    task automatic rd_chk(input logic [7:0] ad, input logic pw);
        logic [7:0] d, e;
        logic       iv;
        model_rd(ad, pw, e);
        i_host.do_read(ad, d, iv);
        if (i_host.timed_out) begin
            fails++;
            report_and_stop();
        end
        if (!pw) `CHK(d, e)
        `CHK(iv, pw)
    endtask : rd_chk

    // low and high byte of one pair on consecutive cycles
    task automatic pair_chk(input logic [7:0] ad);
        logic [7:0] d0, d1, e0, e1;
        model_rd(ad, 1'b0, e0);
        model_rd(ad + 8'h01, 1'b0, e1);
        i_host.do_pair(ad, d0, d1);
        if (i_host.timed_out) begin
            fails++;
            report_and_stop();
        end
        `CHK(d0, e0)
        `CHK(d1, e1)
    endtask : pair_chk

    // main sequence
    initial begin
        {resetn, shadow_dis, data_ready, powering_up, deep_suspend} = 5'h00;
        {any_motion_evt, high_rate_evt} = 2'h0;
        {rate_x, rate_y, rate_z} = 48'h0;
        ce = 1'b1;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        // a new sample lands between the low and high reads of each axis
        for (m = 0; m < 2; m++) begin
            shadow_dis = m[0];
            for (ax = 0; ax < 3; ax++) begin
                load(1'b1);
                rd_chk(8'(2 + 2 * ax), 1'b0);
                load(1'b1);
                rd_chk(8'(3 + 2 * ax), 1'b0);
            end
        end
        shadow_dis = 1'b0;
        load(1'b1);
        load(1'b0);
        // ascending burst across all pairs, reserved slot and status
        for (a = 2; a < 10; a++) rd_chk(8'(a), 1'b0);
        // true bursts: each low read followed at once by its high read
        for (a = 2; a < 8; a += 2) begin
            load(1'b1);
            pair_chk(8'(a));
        end
        @(negedge clk);
        any_motion_evt = 1'b1;
        stat           = 8'h04;
        @(negedge clk);
        any_motion_evt = 1'b0;
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        high_rate_evt = 1'b1;
        stat          = 8'h02;
        @(negedge clk);
        high_rate_evt = 1'b0;
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        // event in the same cycle as the clearing read: the set wins
        any_motion_evt = 1'b1;
        stat           = 8'h04;
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        any_motion_evt = 1'b0;
        stat           = 8'h04;
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        rd_chk(GRR_ADDR_RSVD, 1'b0);
        powering_up = 1'b1;
        rd_chk(GRR_ADDR_Y_LOW, 1'b1);
        powering_up  = 1'b0;
        deep_suspend = 1'b1;
        rd_chk(GRR_ADDR_Z_HIGH, 1'b1);
        deep_suspend = 1'b0;
        rd_chk(GRR_ADDR_Z_HIGH, 1'b0);
        // reset in mid-run drops samples, locks and pending status
        any_motion_evt = 1'b1;
        rd_chk(GRR_ADDR_Y_LOW, 1'b0);
        any_motion_evt = 1'b0;
        resetn         = 1'b0;
        smp            = '{default: 16'h0000};
        lk             = '{default: 0};
        stat           = 8'h00;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd_chk(GRR_ADDR_STATUS0, 1'b0);
        rd_chk(GRR_ADDR_Y_HIGH, 1'b0);
        report_and_stop();
    end
endmodule : test_grr_rate_readout
